// *** rtl/can_filter.sv ***
// Acceptance filters, receive flags and paired buffer control
// Function
// [RULE_01] Sixteen filters, each with writable standard and extended identifier registers.
// [RULE_02] Three masks with standard and extended bits selectable by any filter.
// [RULE_03] Included extended identifier bits must equal the filter bits to match.
// [RULE_04] Mask standard bit one compares that bit; zero makes it don't-care.
// [RULE_05] Mask extended bit one compares that bit; zero excludes it.
// [RULE_06] Mask type bit zero accepts standard or extended messages on bit match.
// [RULE_07] Two-bit mask source per filter picks mask 0..2; 11 reserved; resets zero.
// [RULE_08] Filter 12 has a four-bit target buffer field in bits 3-0.
// [RULE_09] Target code 1111 stores into FIFO; 0000..1110 into buffers 0..14.
// [RULE_10] Storing into buffer n sets its full flag; 32 flags in two registers.
// [RULE_11] Software clears a flag by writing zero; writing one has no effect.
// [RULE_12] Storing into a still-full buffer sets its overflow flag.
// [RULE_13] Each control register holds even buffer in bits 7-0, odd in 15-8.
// [RULE_14] Direction bit one makes a transmit buffer, zero receive; resets zero.
// [RULE_15] Read-only aborted flag shows one when the message was aborted.
// [RULE_16] Read-only arbitration lost flag set when the message lost arbitration.
// [RULE_17] Read-only bus error flag set when a bus error hits the message.
// [RULE_18] Software sets send request; hardware clears on success; software clear aborts.
// [RULE_19] Setting send request clears aborted, arbitration lost and bus error flags.
// [RULE_20] Message contents live in DMA RAM, not in these registers.
// [RULE_21] A stored receive message gets the five-bit accepting filter code.
// [RULE_22] Mask type bit one: filter type bit picks extended-only or standard-only.
// [RULE_23] Pending transmit buffer with highest priority goes first, 11 highest.
// [RULE_24] Auto-remote buffers are requested automatically by a matching remote frame.
// [RULE_25] Accept only when an enabled filter matches all mask-included bits.
//
// The AXI4-Lite register port and the placing of the registers were left to the implementer.
module can_filter
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [7:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [7:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_valid,
	input  wire logic [10:0] rx_sid,
	input  wire logic [17:0] rx_eid,
	input  wire logic        rx_ide,
	input  wire logic        remote_request,
	input  wire logic [2:0]  remote_buffer,
	input  wire logic        tx_done,
	input  wire logic        tx_aborted,
	input  wire logic        tx_arb_lost,
	input  wire logic        tx_bus_error,
	input  wire logic [2:0]  tx_event_buffer,
	output logic             store_valid,
	output logic             store_to_fifo,
	output logic [3:0]       store_buffer,
	output logic [4:0]       accepting_filter_code,
	output logic             tx_pending,
	output logic [2:0]       tx_buffer,
	output logic             abort_request,
	output logic [2:0]       abort_buffer
);
	logic [15:0] filt_sid [16];
	logic [15:0] filt_eid [16];
	logic [15:0] mask_sid [3];
	logic [15:0] mask_eid [3];
	logic [31:0] filter_mask_source;
	logic [3:0]  filter12_target_buffer;
	logic [15:0] filter_enable;
	logic [31:0] receive_buffer_full_flag;
	logic [31:0] receive_buffer_overflow_flag;
	logic [7:0]  buffer_direction;
	logic [7:0]  tx_aborted_flag;
	logic [7:0]  tx_arbitration_lost_flag;
	logic [7:0]  tx_bus_error_flag;
	logic [7:0]  send_request;
	logic [7:0]  auto_remote_reply_enable;
	logic [1:0]  tx_priority [8];
	logic        aw_got;
	logic        w_got;
	logic [7:0]  wr_addr;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;
	logic        wr_en;
	logic [15:0] hit;
	logic        any_hit;
	logic [3:0]  first_hit;
	logic [3:0]  next_target;
	logic [31:0] store_set;
	logic [31:0] full_clear;
	logic [31:0] ovf_clear;
	logic [15:0] rd_word;
	logic        rd_ok;
	logic        next_pending;
	logic [2:0]  next_tx;
	logic [7:0]  abort_hit;

	function automatic logic [15:0] merge(input logic [15:0] old,
		input logic [15:0] data, input logic [1:0] strb,
		input logic [15:0] wmask);
		logic [15:0] lanes;
		lanes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		return (old & ~lanes) | (data & lanes);
	endfunction : merge

	// Bus slave: address and data taken in either order
	assign wr_en = aw_got && w_got && !s_axi_bvalid;

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= can_filter_pkg::RESP_OKAY;
			wr_addr <= 8'h00;
			wr_data <= 32'h00000000;
			wr_strb <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_got <= 1'b1;
				s_axi_awready <= 1'b0;
				wr_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_got <= 1'b1;
				s_axi_wready <= 1'b0;
				wr_data <= s_axi_wdata;
				wr_strb <= s_axi_wstrb;
			end
			if (wr_en)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= decode_ok(wr_addr) ?
					can_filter_pkg::RESP_OKAY : can_filter_pkg::RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready)
			begin
				s_axi_bvalid <= 1'b0;
				aw_got <= 1'b0;
				w_got <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	function automatic logic decode_ok(input logic [7:0] a);
		return a[1:0] == 2'b00 && (a < can_filter_pkg::MASK_SID_BASE ||
			(a >= can_filter_pkg::MASK_SID_BASE && a < 8'h8C) ||
			(a >= can_filter_pkg::MASK_EID_BASE && a < 8'h9C) ||
			(a >= can_filter_pkg::MASK_SEL_LOW && a < 8'hD0));
	endfunction : decode_ok

	// Read multiplexer
	always_comb
	begin
		rd_word = 16'h0000;
		rd_ok = decode_ok(s_axi_araddr);
		if (s_axi_araddr < can_filter_pkg::FILTER_EID_BASE)
			rd_word = filt_sid[s_axi_araddr[5:2]];
		else if (s_axi_araddr < can_filter_pkg::MASK_SID_BASE)
			rd_word = filt_eid[s_axi_araddr[5:2]];
		else if (s_axi_araddr < 8'h8C)
			rd_word = mask_sid[s_axi_araddr[3:2]];
		else if (s_axi_araddr >= can_filter_pkg::MASK_EID_BASE &&
			s_axi_araddr < 8'h9C)
			rd_word = mask_eid[s_axi_araddr[3:2]];
		else if (s_axi_araddr == can_filter_pkg::MASK_SEL_LOW)
			rd_word = filter_mask_source[15:0];
		else if (s_axi_araddr == can_filter_pkg::MASK_SEL_HIGH)
			rd_word = filter_mask_source[31:16];
		else if (s_axi_araddr == can_filter_pkg::BUF_POINTER)
			rd_word = {12'h000, filter12_target_buffer};
		else if (s_axi_araddr == can_filter_pkg::FILTER_ENABLE)
			rd_word = filter_enable;
		else if (s_axi_araddr == can_filter_pkg::FULL_LOW)
			rd_word = receive_buffer_full_flag[15:0];
		else if (s_axi_araddr == can_filter_pkg::FULL_HIGH)
			rd_word = receive_buffer_full_flag[31:16];
		else if (s_axi_araddr == can_filter_pkg::OVF_LOW)
			rd_word = receive_buffer_overflow_flag[15:0];
		else if (s_axi_araddr == can_filter_pkg::OVF_HIGH)
			rd_word = receive_buffer_overflow_flag[31:16];
		else if (s_axi_araddr >= can_filter_pkg::PAIR_CTRL_BASE &&
			s_axi_araddr < 8'hD0)
			rd_word = {ctrl_byte(3'(s_axi_araddr[3:2] * 2 + 1)),
				ctrl_byte(3'(s_axi_araddr[3:2] * 2))}; // see [RULE_13]
	end

	function automatic logic [7:0] ctrl_byte(input logic [2:0] b);
		return {buffer_direction[b], tx_aborted_flag[b],
			tx_arbitration_lost_flag[b], tx_bus_error_flag[b],
			send_request[b], auto_remote_reply_enable[b], tx_priority[b]};
	endfunction : ctrl_byte

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= can_filter_pkg::RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= {16'h0000, rd_ok ? rd_word : 16'h0000};
			s_axi_rresp <= rd_ok ? can_filter_pkg::RESP_OKAY :
				can_filter_pkg::RESP_SLVERR;
		end
		else if (s_axi_rvalid && s_axi_rready)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Filter and mask configuration registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			for (int i = 0; i < 16; i++)
			begin
				filt_sid[i] <= can_filter_pkg::REG_RESET;
				filt_eid[i] <= can_filter_pkg::REG_RESET;
			end
			for (int i = 0; i < 3; i++)
			begin
				mask_sid[i] <= can_filter_pkg::REG_RESET;
				mask_eid[i] <= can_filter_pkg::REG_RESET;
			end
			filter_mask_source <= 32'h00000000; // see [RULE_07]
			filter12_target_buffer <= 4'h0;
			filter_enable <= can_filter_pkg::REG_RESET;
		end
		else if (wr_en)
		begin
			if (wr_addr < can_filter_pkg::FILTER_EID_BASE)
				filt_sid[wr_addr[5:2]] <= merge(filt_sid[wr_addr[5:2]],
					wr_data[15:0], wr_strb[1:0],
					can_filter_pkg::SID_WMASK); // see [RULE_01]
			else if (wr_addr < can_filter_pkg::MASK_SID_BASE)
				filt_eid[wr_addr[5:2]] <= merge(filt_eid[wr_addr[5:2]],
					wr_data[15:0], wr_strb[1:0], 16'hFFFF);
			else if (wr_addr < 8'h8C)
				mask_sid[wr_addr[3:2]] <= merge(mask_sid[wr_addr[3:2]],
					wr_data[15:0], wr_strb[1:0],
					can_filter_pkg::SID_WMASK); // see [RULE_02]
			else if (wr_addr >= can_filter_pkg::MASK_EID_BASE &&
				wr_addr < 8'h9C)
				mask_eid[wr_addr[3:2]] <= merge(mask_eid[wr_addr[3:2]],
					wr_data[15:0], wr_strb[1:0], 16'hFFFF);
			else if (wr_addr == can_filter_pkg::MASK_SEL_LOW)
				filter_mask_source[15:0] <= merge(filter_mask_source[15:0],
					wr_data[15:0], wr_strb[1:0], 16'hFFFF);
			else if (wr_addr == can_filter_pkg::MASK_SEL_HIGH)
				filter_mask_source[31:16] <= merge(filter_mask_source[31:16],
					wr_data[15:0], wr_strb[1:0], 16'hFFFF);
			else if (wr_addr == can_filter_pkg::BUF_POINTER && wr_strb[0])
				filter12_target_buffer <= wr_data[3:0]; // see [RULE_08]
			else if (wr_addr == can_filter_pkg::FILTER_ENABLE)
				filter_enable <= merge(filter_enable, wr_data[15:0],
					wr_strb[1:0], 16'hFFFF);
		end
	end

	// Per-filter match
	for (genvar f = 0; f < 16; f++)
	begin : g_filter
		logic [1:0]  src;
		can_filter_pkg::mask_src_t sel;
		logic [15:0] ms;
		logic [15:0] me;
		logic        sid_ok;
		logic        eid_ok;
		logic        type_ok;
		assign src = filter_mask_source[2 * f +: 2];
		assign sel = src == 2'b00 ? can_filter_pkg::MASK_SRC_0 :
			src == 2'b01 ? can_filter_pkg::MASK_SRC_1 :
			src == 2'b10 ? can_filter_pkg::MASK_SRC_2 :
			can_filter_pkg::MASK_SRC_RSV; // see [RULE_07]
		assign ms = mask_sid[src == 2'b11 ? 2'd0 : src];
		assign me = mask_eid[src == 2'b11 ? 2'd0 : src];
		assign sid_ok = (((rx_sid ^ filt_sid[f][15:5]) & ms[15:5]) ==
			11'h000); // see [RULE_04]
		assign eid_ok = !rx_ide || (((rx_eid ^ {filt_sid[f][1:0],
			filt_eid[f]}) & {ms[1:0], me}) == 18'h00000); // see [RULE_03] [RULE_05]
		assign type_ok = !ms[can_filter_pkg::TYPE_POS] ||
			(filt_sid[f][can_filter_pkg::TYPE_POS] == rx_ide); // see [RULE_06] [RULE_22]
		assign hit[f] = filter_enable[f] && sid_ok && eid_ok && type_ok &&
			sel != can_filter_pkg::MASK_SRC_RSV; // see [RULE_25]
	end

	always_comb
	begin
		first_hit = 4'h0;
		for (int i = 15; i >= 0; i--)
			if (hit[i])
				first_hit = 4'(i);
	end

	assign any_hit = rx_valid && (hit != 16'h0000);
	// Only filter 12 owns a pointer here; the others route to the FIFO
	assign next_target = first_hit == 4'(can_filter_pkg::POINTER_FILTER) ?
		filter12_target_buffer : can_filter_pkg::FIFO_CODE; // see [RULE_09]

	// Store request towards the DMA RAM writer
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			store_valid <= 1'b0;
			store_to_fifo <= 1'b0;
			store_buffer <= 4'h0;
			accepting_filter_code <= 5'h00;
		end
		else
		begin
			store_valid <= any_hit; // see [RULE_20]
			if (any_hit)
			begin
				store_to_fifo <= next_target == can_filter_pkg::FIFO_CODE;
				store_buffer <= next_target;
				accepting_filter_code <= {1'b0, first_hit}; // see [RULE_21]
			end
		end
	end

	// Receive flags: set wins over a software clear
	always_comb
	begin
		store_set = 32'h00000000;
		if (any_hit && next_target != can_filter_pkg::FIFO_CODE)
			store_set[next_target] = 1'b1;
		full_clear = 32'h00000000;
		ovf_clear = 32'h00000000;
		if (wr_en && wr_addr[7:3] == can_filter_pkg::FULL_LOW[7:3])
			full_clear[16 * wr_addr[2] +: 16] = ~wr_data[15:0] &
				{{8{wr_strb[1]}}, {8{wr_strb[0]}}}; // see [RULE_11]
		if (wr_en && wr_addr[7:3] == can_filter_pkg::OVF_LOW[7:3])
			ovf_clear[16 * wr_addr[2] +: 16] = ~wr_data[15:0] &
				{{8{wr_strb[1]}}, {8{wr_strb[0]}}};
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			receive_buffer_full_flag <= 32'h00000000;
			receive_buffer_overflow_flag <= 32'h00000000;
		end
		else
		begin
			receive_buffer_full_flag <= (receive_buffer_full_flag &
				~full_clear) | store_set; // see [RULE_10]
			receive_buffer_overflow_flag <= (receive_buffer_overflow_flag &
				~ovf_clear) | (store_set &
				receive_buffer_full_flag); // see [RULE_12]
		end
	end

	// Paired buffer control, one byte per buffer
	for (genvar b = 0; b < 8; b++)
	begin : g_buffer
		logic       hit_wr;
		logic [7:0] wb;
		logic       req_set;
		assign hit_wr = wr_en && wr_strb[b % 2] && wr_addr ==
			8'(can_filter_pkg::PAIR_CTRL_BASE + 4 * (b / 2)); // see [RULE_13]
		assign wb = wr_data[8 * (b % 2) +: 8];
		assign req_set = (hit_wr && wb[can_filter_pkg::SREQ_POS] &&
			!send_request[b]) || (remote_request && remote_buffer == 3'(b)
			&& buffer_direction[b] && auto_remote_reply_enable[b]); // see [RULE_24]
		// Software dropping a set request asks for an abort
		assign abort_hit[b] = hit_wr && !req_set && send_request[b] &&
			!wb[can_filter_pkg::SREQ_POS];
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				buffer_direction[b] <= 1'b0;
				auto_remote_reply_enable[b] <= 1'b0;
				tx_priority[b] <= 2'b00;
				send_request[b] <= 1'b0;
			end
			else
			begin
				if (hit_wr)
				begin
					buffer_direction[b] <= wb[can_filter_pkg::DIR_POS]; // see [RULE_14]
					auto_remote_reply_enable[b] <= wb[can_filter_pkg::AUTO_REMOTE_REPLY_ENABLE_POS];
					tx_priority[b] <= wb[1:0];
				end
				if (req_set)
					send_request[b] <= 1'b1;
				else if (hit_wr)
					send_request[b] <= wb[can_filter_pkg::SREQ_POS];
				else if (tx_done && tx_event_buffer == 3'(b))
					send_request[b] <= 1'b0; // see [RULE_18]
			end
		end
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				tx_aborted_flag[b] <= 1'b0;
				tx_arbitration_lost_flag[b] <= 1'b0;
				tx_bus_error_flag[b] <= 1'b0;
			end
			else
			begin
				tx_aborted_flag[b] <= (tx_aborted && tx_event_buffer == 3'(b))
					|| (tx_aborted_flag[b] && !req_set); // see [RULE_15] [RULE_19]
				tx_arbitration_lost_flag[b] <= (tx_arb_lost &&
					tx_event_buffer == 3'(b)) ||
					(tx_arbitration_lost_flag[b] && !req_set); // see [RULE_16]
				tx_bus_error_flag[b] <= (tx_bus_error &&
					tx_event_buffer == 3'(b)) ||
					(tx_bus_error_flag[b] && !req_set); // see [RULE_17]
			end
		end
	end

	// Transmit arbitration: highest priority, lowest index on ties
	always_comb
	begin
		next_pending = 1'b0;
		next_tx = 3'd0;
		for (int i = 0; i < 8; i++)
			if (buffer_direction[i] && send_request[i] && (!next_pending ||
				tx_priority[i] > tx_priority[next_tx]))
			begin
				next_pending = 1'b1;
				next_tx = 3'(i); // see [RULE_23]
			end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			tx_pending <= 1'b0;
			tx_buffer <= 3'd0;
			abort_request <= 1'b0;
			abort_buffer <= 3'd0;
		end
		else
		begin
			tx_pending <= next_pending;
			tx_buffer <= next_tx;
			abort_request <= 1'b0;
			for (int i = 0; i < 8; i++)
				if (abort_hit[i])
				begin
					abort_request <= 1'b1;
					abort_buffer <= 3'(i); // see [RULE_18]
				end
		end
	end

	sequence s_accept;
		rx_valid && any_hit;
	endsequence

	a_store_after_hit: assert property (@(posedge aclk) disable iff (!aresetn)
		s_accept |=> store_valid && accepting_filter_code ==
		{1'b0, $past(first_hit)}) else $error("store missing"); // see [RULE_21]
	a_no_hit_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
		!any_hit |=> !store_valid) else $error("store w/o hit"); // see [RULE_25]
	a_full_on_store: assert property (@(posedge aclk) disable iff (!aresetn)
		store_valid && !store_to_fifo |->
		receive_buffer_full_flag[store_buffer]) else $error("full"); // see [RULE_10]
	a_overflow_set: assert property (@(posedge aclk) disable iff (!aresetn)
		s_accept ##0 (next_target != 4'hF &&
		receive_buffer_full_flag[next_target]) |=>
		receive_buffer_overflow_flag[$past(next_target)])
		else $error("overflow"); // see [RULE_12]
	a_pointer_route: assert property (@(posedge aclk) disable iff (!aresetn)
		s_accept ##0 (first_hit == 4'hC) |=> store_buffer ==
		$past(filter12_target_buffer)) else $error("route"); // see [RULE_09]
	a_flags_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
		g_buffer[0].req_set && !tx_aborted && !tx_arb_lost &&
		!tx_bus_error |=> send_request[0] && !tx_aborted_flag[0] &&
		!tx_arbitration_lost_flag[0] && !tx_bus_error_flag[0])
		else $error("flags stay"); // see [RULE_19]
	a_done_clears: assert property (@(posedge aclk) disable iff (!aresetn)
		tx_done && tx_event_buffer == 3'd1 && !g_buffer[1].hit_wr &&
		!g_buffer[1].req_set |=> !send_request[1])
		else $error("request stays"); // see [RULE_18]
	a_pick_follows: assert property (@(posedge aclk) disable iff (!aresetn)
		##1 tx_pending == $past(|(buffer_direction & send_request)))
		else $error("pending"); // see [RULE_23]
	a_resp_holds: assert property (@(posedge aclk) disable iff (!aresetn)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
		$stable(s_axi_bresp)) else $error("bresp dropped");
endmodule : can_filter

// *** rtl/can_filter_pkg.sv ***
// Register map, field layout and reset values of the filter block
package can_filter_pkg;
	localparam logic [7:0] FILTER_SID_BASE = 8'h00;
	localparam logic [7:0] FILTER_EID_BASE = 8'h40;
	localparam logic [7:0] MASK_SID_BASE   = 8'h80;
	localparam logic [7:0] MASK_EID_BASE   = 8'h90;
	localparam logic [7:0] MASK_SEL_LOW    = 8'hA0;
	localparam logic [7:0] MASK_SEL_HIGH   = 8'hA4;
	localparam logic [7:0] BUF_POINTER     = 8'hA8;
	localparam logic [7:0] FILTER_ENABLE   = 8'hAC;
	localparam logic [7:0] FULL_LOW        = 8'hB0;
	localparam logic [7:0] FULL_HIGH       = 8'hB4;
	localparam logic [7:0] OVF_LOW         = 8'hB8;
	localparam logic [7:0] OVF_HIGH        = 8'hBC;
	localparam logic [7:0] PAIR_CTRL_BASE  = 8'hC0;
	localparam logic [15:0] SID_WMASK      = 16'hFFEB;
	localparam logic [7:0]  CTRL_WMASK     = 8'h8F;
	localparam logic [15:0] REG_RESET      = 16'h0000;
	localparam int SID_POS       = 5;
	localparam int TYPE_POS      = 3;
	localparam int DIR_POS       = 7;
	localparam int ABT_POS       = 6;
	localparam int LARB_POS      = 5;
	localparam int BERR_POS      = 4;
	localparam int SREQ_POS      = 3;
	localparam int AUTO_REMOTE_REPLY_ENABLE_POS     = 2;
	localparam int POINTER_FILTER = 12;
	localparam logic [3:0] FIFO_CODE = 4'hF;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	typedef enum logic [3:0]
	{
		MASK_SRC_0   = 4'b0001,
		MASK_SRC_1   = 4'b0010,
		MASK_SRC_2   = 4'b0100,
		MASK_SRC_RSV = 4'b1000
	} mask_src_t;
endpackage : can_filter_pkg

// *** tb/can_acceptance_filter_and_buffer_ctrl_tb.sv ***
// Bench for acceptance filtering, receive flags and buffer control
module can_acceptance_filter_and_buffer_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
	logic        s_axi_arvalid = 1'b0;
	logic        s_axi_bready = 1'b1, s_axi_rready = 1'b1;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
	logic        s_axi_arready, s_axi_rvalid;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        rx_valid, rx_ide, remote_request, tx_done;
	logic        tx_aborted, tx_arb_lost, tx_bus_error;
	logic [10:0] rx_sid;
	logic [17:0] rx_eid;
	logic [2:0]  remote_buffer, tx_event_buffer, tx_buffer;
	logic [2:0]  abort_buffer, last_abort;
	logic        store_valid, store_to_fifo, tx_pending, abort_request;
	logic [3:0]  store_buffer;
	logic [4:0]  accepting_filter_code;
	logic [9:0]  last_store;
	int          mismatches = 0, n_checks = 0, cycles = 0;
	int          stores = 0, aborts = 0;
	can_filter DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .rx_valid, .rx_sid,
		.rx_eid, .rx_ide, .remote_request, .remote_buffer, .tx_done,
		.tx_aborted, .tx_arb_lost, .tx_bus_error, .tx_event_buffer,
		.store_valid, .store_to_fifo, .store_buffer,
		.accepting_filter_code, .tx_pending, .tx_buffer,
		.abort_request, .abort_buffer);
	can_node_model node (.aclk, .rx_valid, .rx_sid, .rx_eid, .rx_ide,
		.remote_request, .remote_buffer, .tx_done, .tx_aborted,
		.tx_arb_lost, .tx_bus_error, .tx_event_buffer);
	always #50 aclk = ~aclk;
	always @(posedge aclk)
	begin
		if (store_valid)
		begin
			stores++;
			last_store <= {store_to_fifo, store_buffer,
				accepting_filter_code};
		end
		if (abort_request)
		begin
			aborts++;
			last_abort <= abort_buffer;
		end
		cycles++;
		if (cycles == 3000)
		begin
			mismatches++;
			results();
		end
	end
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : results
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic tick(input int n);
		repeat (n) @(posedge aclk);
	endtask : tick
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		s_axi_awaddr <= a;
		s_axi_wdata <= {16'h0000, d};
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'b0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid)
				break;
		end
		check("write resp", 32'(s_axi_bresp), 32'(can_filter_pkg::RESP_OKAY));
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		forever
		begin
			@(posedge aclk);
			if (s_axi_arready)
				s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid)
				break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : rd
	task automatic rc(input logic [7:0] a, input logic [15:0] exp);
		logic [31:0] d;
		logic [1:0]  r;
		rd(a, d, r);
		check($sformatf("register %h", a), d, {16'h0000, exp});
	endtask : rc
	task automatic tryf(input logic [10:0] s, input logic [17:0] e,
		input logic i, input int n);
		node.frame(s, e, i);
		tick(2);
		check("stored count", 32'(stores), 32'(n));
	endtask : tryf
	initial
	begin
		logic [31:0] d;
		logic [1:0]  r;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rc(can_filter_pkg::MASK_SEL_HIGH, 16'h0000);
		rc(can_filter_pkg::FULL_HIGH, 16'h0000);
		rc(can_filter_pkg::PAIR_CTRL_BASE + 8'h0C, 16'h0000);
		rd(8'hF0, d, r);
		check("unmapped resp", 32'(r), 32'(can_filter_pkg::RESP_SLVERR));
		$display("test reset done");
		wr(can_filter_pkg::FILTER_SID_BASE, 16'h2460);
		wr(can_filter_pkg::MASK_SID_BASE, 16'hFFE0);
		wr(can_filter_pkg::FILTER_ENABLE, 16'h1001);
		tryf(11'h123, 18'h0, 1'b0, 1);
		check("store info", 32'(last_store), 32'(10'h3E0));
		tryf(11'h122, 18'h0, 1'b0, 1);
		wr(can_filter_pkg::MASK_SID_BASE, 16'hFFC0);
		tryf(11'h122, 18'h0, 1'b0, 2);
		tryf(11'h122, 18'h3FFFF, 1'b1, 3);
		wr(can_filter_pkg::MASK_SEL_LOW, 16'h0003);
		tryf(11'h123, 18'h0, 1'b0, 3);
		$display("test mask done");
		wr(can_filter_pkg::FILTER_SID_BASE + 8'h30, 16'h0AA8);
		wr(can_filter_pkg::FILTER_EID_BASE + 8'h30, 16'h1234);
		wr(can_filter_pkg::MASK_SID_BASE + 8'h04, 16'hFFE8);
		wr(can_filter_pkg::MASK_EID_BASE + 8'h04, 16'hFFFF);
		wr(can_filter_pkg::MASK_SEL_HIGH, 16'h0100);
		wr(can_filter_pkg::BUF_POINTER, 16'h0003);
		tryf(11'h055, 18'h01234, 1'b1, 4);
		check("store info", 32'(last_store), 32'(10'h06C));
		check("store dest", 32'(last_store[9:5]), 32'h3);
		rc(can_filter_pkg::FULL_LOW, 16'h0008);
		tryf(11'h055, 18'h01234, 1'b1, 5);
		rc(can_filter_pkg::OVF_LOW, 16'h0008);
		tryf(11'h055, 18'h01234, 1'b0, 5);
		tryf(11'h055, 18'h01235, 1'b1, 5);
		wr(can_filter_pkg::FULL_LOW, 16'hFFFF);
		rc(can_filter_pkg::FULL_LOW, 16'h0008);
		wr(can_filter_pkg::FULL_LOW, 16'h0000);
		rc(can_filter_pkg::FULL_LOW, 16'h0000);
		$display("test buffers done");
		wr(can_filter_pkg::PAIR_CTRL_BASE, 16'h8B89);
		tick(2);
		check("tx choice", 32'({tx_pending, tx_buffer}), 32'h9);
		node.evt(4'h8, 3'd1);
		tick(2);
		rc(can_filter_pkg::PAIR_CTRL_BASE, 16'h8389);
		check("tx choice", 32'({tx_pending, tx_buffer}), 32'h8);
		node.evt(4'h2, 3'd0);
		tick(1);
		node.evt(4'h1, 3'd1);
		tick(2);
		rc(can_filter_pkg::PAIR_CTRL_BASE, 16'h93A9);
		wr(can_filter_pkg::PAIR_CTRL_BASE, 16'h93A1);
		tick(2);
		check("abort count", 32'(aborts), 32'd1);
		check("abort buffer", 32'(last_abort), 32'd0);
		node.evt(4'h4, 3'd0);
		tick(2);
		rc(can_filter_pkg::PAIR_CTRL_BASE, 16'h93E1);
		wr(can_filter_pkg::PAIR_CTRL_BASE, 16'h97E9);
		rc(can_filter_pkg::PAIR_CTRL_BASE, 16'h9789);
		node.remote(3'd1);
		tick(2);
		rc(can_filter_pkg::PAIR_CTRL_BASE, 16'h8F89);
		$display("test transmit done");
		results();
	end
endmodule : can_acceptance_filter_and_buffer_ctrl_tb

// *** tb/can_node_model.sv ***
// Far-side CAN nodes: delivers frame headers and transmit outcomes
module can_node_model
(
	input  wire logic aclk,
	output logic      rx_valid,
	output logic      [10:0] rx_sid,
	output logic      [17:0] rx_eid,
	output logic      rx_ide,
	output logic      remote_request,
	output logic      [2:0] remote_buffer,
	output logic      tx_done,
	output logic      tx_aborted,
	output logic      tx_arb_lost,
	output logic      tx_bus_error,
	output logic      [2:0] tx_event_buffer
);
	timeunit 1ns;
	timeprecision 1ns;
	initial
	begin
		{rx_valid, rx_sid, rx_eid, rx_ide} = '0;
		{remote_request, remote_buffer} = '0;
		{tx_done, tx_aborted, tx_arb_lost, tx_bus_error} = '0;
		tx_event_buffer = '0;
	end
	// Released lines show the inverse of what they last carried
	task automatic frame(input logic [10:0] s, input logic [17:0] e,
		input logic i);
		{rx_valid, rx_sid, rx_eid, rx_ide} <= {1'b1, s, e, i};
		@(posedge aclk);
		{rx_valid, rx_sid, rx_eid, rx_ide} <= {1'b0, ~s, ~e, ~i};
	endtask : frame
	// Kind order: done, aborted, arbitration lost, bus error
	task automatic evt(input logic [3:0] k, input logic [2:0] b);
		{tx_done, tx_aborted, tx_arb_lost, tx_bus_error} <= k;
		tx_event_buffer <= b;
		@(posedge aclk);
		{tx_done, tx_aborted, tx_arb_lost, tx_bus_error} <= 4'h0;
		tx_event_buffer <= ~b;
	endtask : evt
	task automatic remote(input logic [2:0] b);
		{remote_request, remote_buffer} <= {1'b1, b};
		@(posedge aclk);
		{remote_request, remote_buffer} <= {1'b0, ~b};
	endtask : remote
endmodule : can_node_model
